// [rtl/commutation_delay_defines.vh]
// constants for the commutation delay manager
//
// Contract
// - 8-bit step timer shifts with prescale changes
// - mode select: 0 switched, 1 autoswitched
// - switched: compare match commutates, clears timer
// - commutation loads preloads, sets flag, masked irq
// - direct ratio write only while clock disabled
// - switched: ratio requests act at next commutation
// - both ratio requests together are ignored
// - switched: zero/demag events leave timer alone
// - switched overflow wraps; flag when tacho 00
// - simulated commutation waits for compare write
// - auto simulated: compare match gives commutation
// - auto: commutation leaves timer unchanged
// - hardware zero: capture, shift previous, clear timer
// - simulated zero: shift written latest, clear timer
// - hardware: interval times weight over 256
// - source select 0 uses previous interval
// - source select 1 uses latest interval
// - late compare commutates now, takes timer value
// - speed mode: prescaler follows latest interval
// - auto: FFh bumps prescaler, shifts, restarts 80h
`ifndef COMMUTATION_DELAY_DEFINES_VH
`define COMMUTATION_DELAY_DEFINES_VH
`define TIMER_MAX        8'hFF
`define TIMER_MEDIAN     8'h80
`define TIMER_ZERO       8'h00
`define SPEEDUP_LIMIT    8'h55
`define RATIO_MAX        4'hF
`define RATIO_MIN        4'h0
`define RATIO_RESET      4'h0
`define TACHO_POSITION   2'h0
`define WEIGHT_RESET     8'h00
`endif

// [rtl/commutation_delay_manager.v]
// commutation delay manager: step timer, prescaler, captures and multiplier
`timescale 1ns/1ps
`include "commutation_delay_defines.vh"
module commutation_delay_manager (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       clock_enable_i,
  input  wire       auto_switch_select_i,
  input  wire       simulated_commutation_enable_i,
  input  wire       delay_source_select_i,
  input  wire [1:0] tacho_edge_select_i,
  input  wire       commutation_irq_mask_i,
  input  wire       ratio_write_i,
  input  wire [3:0] ratio_wdata_i,
  input  wire       request_write_i,
  input  wire       request_inc_i,
  input  wire       request_dec_i,
  input  wire       compare_write_i,
  input  wire [7:0] compare_wdata_i,
  input  wire       latest_write_i,
  input  wire [7:0] latest_wdata_i,
  input  wire       previous_write_i,
  input  wire [7:0] previous_wdata_i,
  input  wire       demag_write_i,
  input  wire [7:0] demag_wdata_i,
  input  wire       weight_write_i,
  input  wire [7:0] weight_wdata_i,
  input  wire       flag_clear_i,
  input  wire       overflow_clear_i,
  input  wire       zero_hw_i,
  input  wire       zero_sim_i,
  input  wire       demag_event_i,
  output reg  [7:0] step_timer_o,
  output reg  [7:0] commutation_compare_o,
  output reg  [7:0] latest_interval_o,
  output reg  [7:0] previous_interval_o,
  output reg  [7:0] demag_compare_o,
  output reg  [7:0] delay_weight_o,
  output reg  [3:0] prescale_ratio_o,
  output reg        ratio_increment_request_o,
  output reg        ratio_decrement_request_o,
  output reg        commutation_flag_o,
  output reg        overflow_flag_o,
  output reg        commutation_irq_o,
  output reg        preload_strobe_o,
  output reg        commutation_event_o
);

  reg  [15:0] prescale_count;
  reg         compare_armed;
  reg         mult_pending;
  reg  [15:0] next_prescale_count;
  reg  [7:0]  next_step_timer;
  reg  [3:0]  next_prescale_ratio;
  reg         next_increment_request;
  reg         next_decrement_request;

  // prescaled tick: ratio n divides the clock by 2^n
  function [15:0] tick_limit;
    input [3:0] r;
    begin
      tick_limit = (16'h0001 << r) - 16'h0001;
    end
  endfunction

  // product of interval and weight over 256
  function [7:0] scaled_delay;
    input [7:0] iv;
    input [7:0] w;
    reg   [15:0] p;
    begin
      p = iv * w;
      scaled_delay = p[15:8];
    end
  endfunction

  wire        speed_mode = (tacho_edge_select_i != `TACHO_POSITION);
  wire        tick = clock_enable_i &&
                     (prescale_count >= tick_limit(prescale_ratio_o));
  wire        sim_mode = simulated_commutation_enable_i;
  wire [7:0]  interval_operand = delay_source_select_i ? latest_interval_o
                                                       : previous_interval_o;
  wire [7:0]  product = scaled_delay(interval_operand, delay_weight_o);
  wire        sw_match = !auto_switch_select_i && !speed_mode &&
                         (!sim_mode || compare_armed) &&
                         (step_timer_o == commutation_compare_o);
  wire        sim_match = auto_switch_select_i && sim_mode && compare_armed &&
                          (step_timer_o == commutation_compare_o);
  wire        hw_match = auto_switch_select_i && !sim_mode && !mult_pending &&
                         compare_armed && (step_timer_o == commutation_compare_o);
  wire        late_hw = auto_switch_select_i && !sim_mode && mult_pending &&
                        (product <= step_timer_o);
  wire        commutate = clock_enable_i && !speed_mode &&
                          (sw_match || sim_match || hw_match || late_hw);
  wire        zero_event = clock_enable_i && auto_switch_select_i &&
                           (zero_hw_i || zero_sim_i);
  wire        inc_req = ratio_increment_request_o && !ratio_decrement_request_o;
  wire        dec_req = ratio_decrement_request_o && !ratio_increment_request_o;
  wire        sw_shift_up = commutate && !auto_switch_select_i && inc_req &&
                            (prescale_ratio_o != `RATIO_MAX);
  wire        sw_shift_dn = commutate && !auto_switch_select_i && dec_req &&
                            (prescale_ratio_o != `RATIO_MIN);
  wire        auto_top = tick && auto_switch_select_i &&
                         (step_timer_o == `TIMER_MAX);
  wire        auto_up = auto_top && (prescale_ratio_o != `RATIO_MAX);
  // speed-up only on a zero event with a short interval
  wire        auto_dn = zero_event && (step_timer_o < `SPEEDUP_LIMIT) &&
                        (prescale_ratio_o != `RATIO_MIN) && !speed_mode;
  // speed mode prescaler tracks the latest capture
  wire        spd_up = speed_mode && tick && (step_timer_o == `TIMER_MAX) &&
                       (prescale_ratio_o != `RATIO_MAX);
  wire        spd_dn = speed_mode && zero_hw_i && clock_enable_i &&
                       (latest_interval_o < `SPEEDUP_LIMIT) &&
                       (prescale_ratio_o != `RATIO_MIN);
  wire        shift_r = sw_shift_up || auto_up || spd_up;
  wire        shift_l = (sw_shift_dn || auto_dn || spd_dn) && !shift_r;

  always @* begin
    if (!clock_enable_i || tick || commutate || zero_event)
      next_prescale_count = 16'h0000;
    else
      next_prescale_count = prescale_count + 16'h0001;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      prescale_count <= 16'h0000;
    end else begin
      prescale_count <= next_prescale_count;
    end
  end

  // both strobes come from one decision, so preloads and the event
  // pulse can never be seen apart
  always @(posedge clk_i) begin
    if (rst_i) begin
      preload_strobe_o    <= 1'b0;
      commutation_event_o <= 1'b0;
    end else begin
      preload_strobe_o    <= commutate;
      commutation_event_o <= commutate;
    end
  end

  // step timer: zero events win over commutation and shifts
  always @* begin
    next_step_timer = step_timer_o;
    if (zero_event) begin
      next_step_timer = `TIMER_ZERO;
    end else if (commutate && !auto_switch_select_i) begin
      next_step_timer = `TIMER_ZERO;
    end else if (shift_r && auto_top) begin
      next_step_timer = `TIMER_MEDIAN;
    end else if (shift_r) begin
      next_step_timer = {1'b0, step_timer_o[7:1]};
    end else if (shift_l) begin
      next_step_timer = {step_timer_o[6:0], 1'b0};
    end else if (tick) begin
      next_step_timer = step_timer_o + 8'h01;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      step_timer_o <= `TIMER_ZERO;
    end else begin
      step_timer_o <= next_step_timer;
    end
  end

  // timer wrap sets overflow in position modes
  always @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_o <= 1'b0;
    end else begin
      if (tick && step_timer_o == `TIMER_MAX && !shift_r &&
          tacho_edge_select_i == `TACHO_POSITION)
        overflow_flag_o <= 1'b1;
      else if (overflow_clear_i)
        overflow_flag_o <= 1'b0;
    end
  end

  // prescale ratio: direct load only while stopped, later only steps of one
  always @* begin
    next_prescale_ratio = prescale_ratio_o;
    if (!clock_enable_i && ratio_write_i)
      next_prescale_ratio = ratio_wdata_i;
    else if (shift_r)
      next_prescale_ratio = prescale_ratio_o + 4'h1;
    else if (shift_l)
      next_prescale_ratio = prescale_ratio_o - 4'h1;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      prescale_ratio_o <= `RATIO_RESET;
    end else begin
      prescale_ratio_o <= next_prescale_ratio;
    end
  end

  // zero-crossing captures and shifted interval registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      latest_interval_o   <= `TIMER_ZERO;
      previous_interval_o <= `TIMER_ZERO;
    end else begin
      if (zero_event && zero_hw_i) begin
        latest_interval_o   <= step_timer_o;
        previous_interval_o <= latest_interval_o;
      end else if (zero_event) begin
        previous_interval_o <= latest_interval_o;
      end else if (spd_dn) begin
        latest_interval_o   <= step_timer_o;
      end else begin
        if (latest_write_i)
          latest_interval_o <= latest_wdata_i;
        else if (shift_r)
          latest_interval_o <= {1'b0, latest_interval_o[7:1]};
        else if (shift_l)
          latest_interval_o <= {latest_interval_o[6:0], 1'b0};
        if (previous_write_i)
          previous_interval_o <= previous_wdata_i;
        else if (shift_r)
          previous_interval_o <= {1'b0, previous_interval_o[7:1]};
        else if (shift_l)
          previous_interval_o <= {previous_interval_o[6:0], 1'b0};
      end
    end
  end

  // demag register follows every timer shift to keep its time meaning
  always @(posedge clk_i) begin
    if (rst_i) begin
      demag_compare_o <= `TIMER_ZERO;
    end else begin
      if (demag_write_i)
        demag_compare_o <= demag_wdata_i;
      else if (demag_event_i && clock_enable_i && auto_switch_select_i)
        demag_compare_o <= step_timer_o;
      else if (shift_r)
        demag_compare_o <= {1'b0, demag_compare_o[7:1]};
      else if (shift_l)
        demag_compare_o <= {demag_compare_o[6:0], 1'b0};
    end
  end

  // weight is a ratio, so it is never shifted with the timer
  always @(posedge clk_i) begin
    if (rst_i) begin
      delay_weight_o <= `WEIGHT_RESET;
    end else begin
      if (weight_write_i)
        delay_weight_o <= weight_wdata_i;
    end
  end

  // compare register; multiply result scheduled after zero event
  always @(posedge clk_i) begin
    if (rst_i) begin
      commutation_compare_o <= `TIMER_ZERO;
      compare_armed         <= 1'b0;
      mult_pending          <= 1'b0;
    end else begin
      if (compare_write_i) begin
        commutation_compare_o <= compare_wdata_i;
        compare_armed         <= 1'b1;
        mult_pending          <= 1'b0;
      end else if (late_hw) begin
        commutation_compare_o <= step_timer_o;
        compare_armed         <= 1'b0;
        mult_pending          <= 1'b0;
      end else if (mult_pending) begin
        commutation_compare_o <= product;
        compare_armed         <= 1'b1;
        mult_pending          <= 1'b0;
      end else if (zero_event && !sim_mode) begin
        mult_pending          <= 1'b1;
      end else if (shift_r || shift_l) begin
        commutation_compare_o <= shift_r ? {1'b0, commutation_compare_o[7:1]}
                                         : {commutation_compare_o[6:0], 1'b0};
        // recompute after shifting for full precision
        mult_pending          <= auto_switch_select_i && !sim_mode && compare_armed;
      end else if (commutate && (sim_mode || auto_switch_select_i)) begin
        compare_armed         <= 1'b0;
      end
    end
  end

  // ratio requests: a set from software beats hardware clear
  always @* begin
    next_increment_request = ratio_increment_request_o;
    next_decrement_request = ratio_decrement_request_o;
    if (request_write_i && !(request_inc_i && request_dec_i)) begin
      next_increment_request = request_inc_i;
      next_decrement_request = request_dec_i;
    end else if (commutate && !auto_switch_select_i) begin
      next_increment_request = 1'b0;
      next_decrement_request = 1'b0;
    end else if (auto_up) begin
      next_increment_request = 1'b1;
    end else if (auto_dn) begin
      next_decrement_request = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ratio_increment_request_o <= 1'b0;
      ratio_decrement_request_o <= 1'b0;
    end else begin
      ratio_increment_request_o <= next_increment_request;
      ratio_decrement_request_o <= next_decrement_request;
    end
  end

  // a commutation in the clear cycle keeps the flag set
  always @(posedge clk_i) begin
    if (rst_i) begin
      commutation_flag_o <= 1'b0;
    end else begin
      if (commutate)
        commutation_flag_o <= 1'b1;
      else if (flag_clear_i)
        commutation_flag_o <= 1'b0;
    end
  end

  // the request follows the flag at the same edge, so it never lags it
  always @(posedge clk_i) begin
    if (rst_i) begin
      commutation_irq_o <= 1'b0;
    end else begin
      commutation_irq_o <= (commutate || commutation_flag_o) &&
                           !(flag_clear_i && !commutate) &&
                           commutation_irq_mask_i;
    end
  end

endmodule

// [tb/commutation_delay_manager_props.sv]
// assertion checker for the commutation delay manager
`timescale 1ns/1ps
module commutation_delay_manager_props (
  input wire       clk_i,
  input wire       rst_i,
  input wire       clock_enable_i,
  input wire       auto_switch_select_i,
  input wire       simulated_commutation_enable_i,
  input wire [1:0] tacho_edge_select_i,
  input wire       commutation_irq_mask_i,
  input wire       request_write_i,
  input wire       request_inc_i,
  input wire       request_dec_i,
  input wire       zero_hw_i,
  input wire [7:0] step_timer_o,
  input wire [7:0] commutation_compare_o,
  input wire [7:0] latest_interval_o,
  input wire [7:0] previous_interval_o,
  input wire [3:0] prescale_ratio_o,
  input wire       ratio_increment_request_o,
  input wire       ratio_decrement_request_o,
  input wire       commutation_irq_o,
  input wire       commutation_flag_o,
  input wire       preload_strobe_o,
  input wire       commutation_event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire sw = clock_enable_i && !auto_switch_select_i && tacho_edge_select_i == 2'h0;
  // only the undivided tick rate gives an exact per-cycle step
  wire fast = sw && prescale_ratio_o == 4'h0;
  wire idle = !ratio_increment_request_o && !ratio_decrement_request_o && !request_write_i;
  sequence s_match;
    fast && !simulated_commutation_enable_i && commutation_compare_o != 8'h00
      && step_timer_o == commutation_compare_o;
  endsequence
  sequence s_clear_event;
    step_timer_o == 8'h00 ##[0:1] commutation_event_o;
  endsequence
  a_match_commutates: assert property (s_match |=> s_clear_event)
    else $error("compare match did not clear timer and commutate");
  a_timer_steps_one: assert property (
    fast && step_timer_o != commutation_compare_o |=> step_timer_o == $past(step_timer_o) + 8'h01)
    else $error("timer did not advance by one");
  a_timer_holds_off: assert property (
    !clock_enable_i |=> $stable(step_timer_o)) else $error("timer moved while disabled");
  a_ratio_locked_run: assert property (
    $past(sw && idle) |-> $stable(prescale_ratio_o)) else $error("prescale changed while running");
  a_both_requests_ignored: assert property (
    request_write_i && request_inc_i && request_dec_i && !clock_enable_i
    |=> $stable(ratio_increment_request_o) && $stable(ratio_decrement_request_o))
    else $error("double ratio request changed state");
  a_preload_with_event: assert property (
    commutation_event_o |-> preload_strobe_o && commutation_flag_o)
    else $error("preload or flag missing at commutation");
  a_irq_masked_off: assert property (
    !commutation_irq_mask_i && $past(!commutation_irq_mask_i) |-> !commutation_irq_o)
    else $error("interrupt raised while masked");
  a_zero_capture: assert property (
    clock_enable_i && auto_switch_select_i && tacho_edge_select_i == 2'h0 && zero_hw_i
    && prescale_ratio_o == 4'h0 && step_timer_o != 8'hFF
    |=> latest_interval_o == $past(step_timer_o) && step_timer_o == 8'h00
    && previous_interval_o == $past(latest_interval_o)) else $error("zero capture wrong");
endmodule
bind commutation_delay_manager commutation_delay_manager_props i_commutation_delay_manager_props (.*);

// [tb/back_emf_detector.sv]
// model of the zero-crossing and demagnetization detectors
`timescale 1ns/1ps
module back_emf_detector (
  input  wire  clk_i,
  output logic zero_hw_o,
  output logic zero_sim_o,
  output logic demag_event_o
);
  initial {zero_hw_o, zero_sim_o, demag_event_o} = 3'h0;
  // one-cycle pulse, then a quiet cycle so pulses never merge
  task automatic fire(input int k);
    {zero_hw_o, zero_sim_o, demag_event_o} = 3'h4 >> k;
    @(posedge clk_i);
    #1 {zero_hw_o, zero_sim_o, demag_event_o} = 3'h0;
    @(posedge clk_i);
    #1;
  endtask
endmodule

// [tb/testbench.sv]
// self-checking testbench of the commutation delay manager
`timescale 1ns/1ps
module testbench;
  logic       clk_i, rst_i, clock_enable_i, auto_switch_select_i, delay_source_select_i;
  logic       simulated_commutation_enable_i, commutation_irq_mask_i, request_write_i;
  logic       request_inc_i, request_dec_i;
  logic [1:0] tacho_edge_select_i;
  logic [7:0] wsel, wdata;
  wire        ratio_write_i, compare_write_i, latest_write_i, previous_write_i, demag_write_i;
  wire        weight_write_i, flag_clear_i, overflow_clear_i, zero_hw_i, zero_sim_i, demag_event_i;
  wire  [3:0] ratio_wdata_i, prescale_ratio_o;
  wire  [7:0] compare_wdata_i, latest_wdata_i, previous_wdata_i, demag_wdata_i, weight_wdata_i;
  wire  [7:0] step_timer_o, commutation_compare_o, latest_interval_o, previous_interval_o;
  wire  [7:0] demag_compare_o, delay_weight_o;
  wire        ratio_increment_request_o, ratio_decrement_request_o, commutation_flag_o;
  wire        overflow_flag_o, commutation_irq_o, preload_strobe_o, commutation_event_o;
  int         fails, checked, evts, mark;
  assign {ratio_write_i, compare_write_i, latest_write_i, previous_write_i, demag_write_i,
          weight_write_i, flag_clear_i, overflow_clear_i} = wsel;
  assign ratio_wdata_i = wdata[3:0];
  assign {compare_wdata_i, latest_wdata_i, previous_wdata_i, demag_wdata_i, weight_wdata_i} = {5{wdata}};
  commutation_delay_manager i_commutation_delay_manager (.*);
  back_emf_detector i_back_emf_detector (.clk_i(clk_i), .zero_hw_o(zero_hw_i),
    .zero_sim_o(zero_sim_i), .demag_event_o(demag_event_i));
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) evts += int'(commutation_event_o === 1'h1);
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    wdata = d;
    wsel = 8'h80 >> k;
    tick();
    wsel = 8'h00;
    tick();
  endtask
  task automatic req(input logic inc, input logic dec);
    {request_write_i, request_inc_i, request_dec_i} = {1'h1, inc, dec};
    tick();
    request_write_i = 1'h0;
    tick();
  endtask
  task automatic wait_evt(input int n);
    for (int i = 0; i < n && commutation_event_o !== 1'h1; i++) tick();
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    fails++;
    summarize();
  end
  initial begin
    {rst_i, wsel, wdata, request_write_i, request_inc_i, request_dec_i} = 20'h80000;
    {clock_enable_i, auto_switch_select_i, delay_source_select_i} = 3'h0;
    {simulated_commutation_enable_i, commutation_irq_mask_i, tacho_edge_select_i} = 4'h0;
    repeat (4) tick();
    rst_i = 1'h0;
    wr(1, 8'h03);
    wr(0, 8'h02);
    check(prescale_ratio_o, 8'h02);
    clock_enable_i = 1'h1;
    wr(0, 8'h05);
    check(prescale_ratio_o, 8'h02);
    clock_enable_i = 1'h0;
    wr(0, 8'h00);
    req(1'h1, 1'h0);
    req(1'h1, 1'h1);
    check({ratio_increment_request_o, ratio_decrement_request_o}, 8'h02);
    $display("test prescale access done");
    commutation_irq_mask_i = 1'h1;
    clock_enable_i = 1'h1;
    wait_evt(300);
    check(commutation_event_o, 8'h01);
    tick();
    check({prescale_ratio_o, ratio_increment_request_o}, 8'h02);
    check({commutation_flag_o, commutation_irq_o}, 8'h03);
    {clock_enable_i, commutation_irq_mask_i} = 2'h0;
    wr(6, 8'h00);
    check({commutation_flag_o, commutation_irq_o}, 8'h00);
    $display("test switched commutation done");
    {rst_i, simulated_commutation_enable_i} = 2'h3;
    repeat (2) tick();
    {rst_i, clock_enable_i} = 2'h1;
    i_back_emf_detector.fire(0);
    i_back_emf_detector.fire(2);
    check(latest_interval_o | demag_compare_o, 8'h00);
    repeat (270) tick();
    check({overflow_flag_o, commutation_flag_o}, 8'h02);
    wr(7, 8'h00);
    wr(1, 8'h10);
    wait_evt(300);
    check(commutation_event_o, 8'h01);
    $display("test simulated commutation done");
    {rst_i, simulated_commutation_enable_i, auto_switch_select_i, clock_enable_i} = 4'hA;
    repeat (2) tick();
    rst_i = 1'h0;
    wr(2, 8'h40);
    wr(3, 8'h11);
    wr(5, 8'h80);
    clock_enable_i = 1'h1;
    i_back_emf_detector.fire(1);
    check(previous_interval_o, 8'h40);
    check(commutation_compare_o, 8'h20);
    i_back_emf_detector.fire(0);
    check(previous_interval_o, 8'h40);
    check(commutation_compare_o, 8'h20);
    wait_evt(60);
    tick();
    check(step_timer_o >= 8'h20, 8'h01);
    wr(5, 8'h00);
    mark = evts;
    i_back_emf_detector.fire(0);
    tick();
    check(evts > mark, 8'h01);
    repeat (300) tick();
    check({prescale_ratio_o, ratio_increment_request_o}, 8'h03);
    check(step_timer_o >= 8'h80, 8'h01);
    $display("test autoswitched done");
    {rst_i, auto_switch_select_i, clock_enable_i, delay_source_select_i} = 4'hD;
    repeat (2) tick();
    rst_i = 1'h0;
    wr(2, 8'h60);
    wr(5, 8'h80);
    clock_enable_i = 1'h1;
    repeat (64) tick();
    i_back_emf_detector.fire(0);
    check(latest_interval_o, 8'h40);
    check(previous_interval_o, 8'h60);
    check(commutation_compare_o, 8'h20);
    tacho_edge_select_i = 2'h1;
    mark = evts;
    repeat (300) tick();
    check(evts == mark, 8'h01);
    check({prescale_ratio_o, overflow_flag_o}, 8'h02);
    $display("test speed mode done");
    summarize();
  end
endmodule
